// ==== hdl/oad_defs.svh ====
// Constants of the operand address decoder: addresses, vectors and reset values.
// Assumes inclusion by the core module only.
`ifndef OAD_DEFS_SVH
`define OAD_DEFS_SVH
`define OAD_RESET_PC 16'h0000
`define OAD_RESET_SP 8'h07
`define OAD_BIT_RAM_BASE 8'h20
`define OAD_VEC_EXT0 16'h0003
`define OAD_VEC_TMR0 16'h000b
`define OAD_VEC_EXT1 16'h0013
`define OAD_VEC_TMR1 16'h001b
`define OAD_VEC_SER 16'h0023
`define OAD_VEC_PWM 16'h002b
`define OAD_ADDR_ACC 8'he0
`define OAD_ADDR_B 8'hf0
`define OAD_ADDR_DPL 8'h82
`define OAD_ADDR_PSW 8'hd0
`define OAD_CY_BIT 3'h7
`endif

// ==== hdl/oad_pkg.sv ====
// Types of the operand address decoder: modes, spaces, request and answer.
// Assumes the core sequencer drives requests of type oad_req_t.
package oad_pkg;
    // Addressing mode of one request.
    typedef enum logic [3:0] {
        OAD_M_REG = 4'h0, OAD_M_DIR = 4'h1, OAD_M_IND = 4'h2, OAD_M_IMM = 4'h3,
        OAD_M_BASE = 4'h4, OAD_M_PUSH = 4'h5, OAD_M_POP = 4'h6, OAD_M_CALL = 4'h7,
        OAD_M_VECT = 4'h8, OAD_M_BIT = 4'h9, OAD_M_IMPL = 4'ha, OAD_M_JUMP = 4'hb
    } oad_mode_t;
    // Memory space that an access reaches.
    typedef enum logic [2:0] {
        OAD_S_NONE = 3'h0, OAD_S_IRAM = 3'h1, OAD_S_SFR = 3'h2, OAD_S_PROG = 3'h3, OAD_S_IMM = 3'h4
    } oad_space_t;
    // Decoder sequencing states.
    typedef enum logic [0:0] {
        OAD_ST_IDLE = 1'b0, OAD_ST_CALL_HI = 1'b1
    } oad_state_t;
    // Request from the sequencer.
    typedef struct packed {
        oad_mode_t mode;
        logic [7:0] opcode;
        logic [7:0] operand;
        logic [15:0] target;
        logic sel;
    } oad_req_t;
    // Decoded access towards memories.
    typedef struct packed {
        oad_space_t space;
        logic [15:0] addr;
        logic bit_valid;
        logic [2:0] bit_idx;
        logic [7:0] data;
        logic src_valid;
        oad_space_t src_space;
        logic [7:0] src_addr;
    } oad_acc_t;
endpackage

// ==== hdl/oad_core.sv ====
// Operand address decoder: maps addressing modes onto RAM, special registers and program space.
// Assumes one request at a time from the sequencer, taken while o_ready is high.
//
// Behaviour
// RQ1 - Register mode: opcode low bits pick bank register.
// RQ2 - Four eight-register banks at RAM 0 to 31.
// RQ3 - Direct byte: top bit selects RAM or specials.
// RQ4 - Special registers reachable only by direct addressing.
// RQ5 - Indirect pointer reaches full 256-byte RAM.
// RQ6 - Push and pop go indirect through stack pointer.
// RQ7 - Calls save program counter on the stack.
// RQ8 - Any direct byte may be pushed or popped.
// RQ9 - Direct mode consumes one extra program byte.
// RQ10 - Immediate byte is the operand value itself.
// RQ11 - Base-index reads program at accumulator plus base.
// RQ12 - Sixteen-bit program counter spans 64 Kbyte.
// RQ13 - Instructions fetched only from program space.
// RQ14 - Execution starts at address 0000 after reset.
// RQ15 - Six interrupt vectors, priority chosen elsewhere.
// RQ16 - Vectors at 03, 0B, 13, 1B, 23, 2B.
// RQ17 - 128 RAM bits live in bytes 32 to 47.
// RQ18 - Upper RAM only indirect, shares special addresses.
// RQ19 - Special registers occupy addresses 128 to 255.
// RQ20 - Special register bits only at multiples of eight.
// RQ21 - Accumulator, B, data pointer, carry as implicit operands.
// RQ22 - Bank bits 00..11 select 00h, 08h, 10h, 18h.
// RQ23 - Bit addresses below 128 map to RAM bytes.
`timescale 1ns/1ps
`include "oad_defs.svh"
module oad_core import oad_pkg::*; (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // Request from the sequencer.
    input wire logic i_req_valid,
    input wire oad_req_t i_req,
    // Status word bank bits and implicit operands.
    input wire logic i_bank_select_high,
    input wire logic i_bank_select_low,
    input wire logic [7:0] i_accumulator,
    input wire logic [15:0] i_data_pointer,
    // Program counter advance and stack pointer reload.
    input wire logic i_pc_step,
    input wire logic i_sp_load,
    input wire logic [7:0] i_sp_value,
    // Answer towards memories.
    output logic o_ready,
    output logic o_acc_valid,
    output oad_acc_t o_acc,
    // Program counter, fetch address and stack pointer.
    output logic [15:0] o_pc,
    output logic [15:0] o_fetch_addr,
    output logic [7:0] o_stack_pointer
);
    oad_state_t state_ff; // Sequencing state.
    oad_state_t nxt_state;
    logic [15:0] pc_ff; // Program counter.
    logic [15:0] nxt_pc;
    logic [7:0] sp_ff; // Stack pointer.
    logic [7:0] nxt_sp;
    logic [15:0] call_target_ff; // Target kept between the two call pushes.
    logic acc_valid_ff; // Answer strobe.
    oad_acc_t acc_ff; // Answer contents.
    oad_acc_t nxt_acc;
    logic take; // A request is accepted this cycle.
    logic [1:0] bank; // Active bank number.
    logic [15:0] vector; // Interrupt entry for the requested source.

    assign take = i_req_valid && (state_ff == OAD_ST_IDLE);
    assign bank = {i_bank_select_high, i_bank_select_low}; // RQ22
    assign o_ready = (state_ff == OAD_ST_IDLE);
    assign o_acc_valid = acc_valid_ff;
    assign o_acc = acc_ff;
    assign o_pc = pc_ff;
    assign o_fetch_addr = pc_ff; // RQ13
    assign o_stack_pointer = sp_ff;

    // Vector lookup; priority between sources is resolved by the interrupt logic.
    always_comb
    begin
        case (i_req.opcode[2:0]) // RQ15
            3'h0: vector = `OAD_VEC_EXT0; // RQ16
            3'h1: vector = `OAD_VEC_TMR0;
            3'h2: vector = `OAD_VEC_EXT1;
            3'h3: vector = `OAD_VEC_TMR1;
            3'h4: vector = `OAD_VEC_SER;
            3'h5: vector = `OAD_VEC_PWM;
            default: vector = `OAD_VEC_EXT0;
        endcase
    end

    // Decode the accepted request into one access, or the second call push.
    always_comb
    begin
        nxt_acc = '0;
        nxt_state = state_ff;
        if (state_ff == OAD_ST_CALL_HI)
        begin
            // Second push of a call carries the high byte of the return address.
            // The pointer only moves at the end of the call, so the second byte goes two above it.
            nxt_acc.space = OAD_S_IRAM;
            nxt_acc.addr = {8'h00, 8'(sp_ff + 8'h02)}; // RQ7
            nxt_acc.data = pc_ff[15:8];
            nxt_state = OAD_ST_IDLE;
        end
        else if (take)
        begin
            case (i_req.mode)
                OAD_M_REG:
                begin
                    // Bank register in RAM 0..31.
                    nxt_acc.space = OAD_S_IRAM;
                    nxt_acc.addr = {11'h000, bank, i_req.opcode[2:0]}; // RQ1 RQ2
                end
                OAD_M_DIR:
                begin
                    // Top bit splits lower RAM from the special registers.
                    nxt_acc.space = i_req.operand[7] ? OAD_S_SFR : OAD_S_IRAM; // RQ3 RQ19
                    nxt_acc.addr = {8'h00, i_req.operand}; // RQ9
                end
                OAD_M_IND:
                begin
                    // Pointer contents always land in RAM, upper half included.
                    nxt_acc.space = OAD_S_IRAM; // RQ4 RQ5 RQ18
                    nxt_acc.addr = {8'h00, i_req.operand};
                end
                OAD_M_IMM:
                begin
                    // The fetched byte is the value itself.
                    nxt_acc.space = OAD_S_IMM; // RQ10
                    nxt_acc.addr = pc_ff;
                    nxt_acc.data = i_req.operand;
                end
                OAD_M_BASE:
                begin
                    // Table read from program space only.
                    nxt_acc.space = OAD_S_PROG;
                    nxt_acc.addr = (i_req.sel ? pc_ff : i_data_pointer) + {8'h00, i_accumulator}; // RQ11
                end
                OAD_M_PUSH:
                begin
                    // Destination is RAM at the raised pointer; source any direct byte.
                    nxt_acc.space = OAD_S_IRAM; // RQ6
                    nxt_acc.addr = {8'h00, 8'(sp_ff + 8'h01)};
                    nxt_acc.src_valid = 1'b1; // RQ8
                    nxt_acc.src_space = i_req.operand[7] ? OAD_S_SFR : OAD_S_IRAM;
                    nxt_acc.src_addr = i_req.operand;
                end
                OAD_M_POP:
                begin
                    // Source is RAM at the pointer; destination any direct byte.
                    nxt_acc.space = OAD_S_IRAM; // RQ6
                    nxt_acc.addr = {8'h00, sp_ff};
                    nxt_acc.src_valid = 1'b1; // RQ8
                    nxt_acc.src_space = i_req.operand[7] ? OAD_S_SFR : OAD_S_IRAM;
                    nxt_acc.src_addr = i_req.operand;
                end
                OAD_M_CALL, OAD_M_VECT:
                begin
                    // First push carries the low byte of the return address.
                    nxt_acc.space = OAD_S_IRAM; // RQ7
                    nxt_acc.addr = {8'h00, 8'(sp_ff + 8'h01)};
                    nxt_acc.data = pc_ff[7:0];
                    nxt_state = OAD_ST_CALL_HI;
                end
                OAD_M_BIT:
                begin
                    nxt_acc.bit_valid = 1'b1;
                    nxt_acc.bit_idx = i_req.operand[2:0];
                    if (!i_req.operand[7])
                    begin
                        // RAM bits: eight per byte from byte 32 upward.
                        nxt_acc.space = OAD_S_IRAM; // RQ17 RQ23
                        nxt_acc.addr = {8'h00, `OAD_BIT_RAM_BASE + {4'h0, i_req.operand[6:3]}};
                    end
                    else
                    begin
                        // Special register bits only in registers at multiples of eight.
                        nxt_acc.space = OAD_S_SFR; // RQ20 RQ23
                        nxt_acc.addr = {8'h00, i_req.operand[7:3], 3'h0};
                    end
                end
                OAD_M_IMPL:
                begin
                    // Implicit operands resolve to their special register homes.
                    nxt_acc.space = OAD_S_SFR; // RQ21
                    case (i_req.opcode[1:0])
                        2'h0: nxt_acc.addr = {8'h00, `OAD_ADDR_ACC};
                        2'h1: nxt_acc.addr = {8'h00, `OAD_ADDR_B};
                        2'h2: nxt_acc.addr = {8'h00, `OAD_ADDR_DPL};
                        default:
                        begin
                            // Carry is bit 7 of the status word.
                            nxt_acc.addr = {8'h00, `OAD_ADDR_PSW};
                            nxt_acc.bit_valid = 1'b1;
                            nxt_acc.bit_idx = `OAD_CY_BIT;
                        end
                    endcase
                end
                default:
                begin
                    // Jump and unknown modes produce no data access.
                    nxt_acc.space = OAD_S_NONE;
                end
            endcase
        end
    end

    // Next program counter: loads on jump and call completion, else steps.
    always_comb
    begin
        nxt_pc = pc_ff + {15'h0000, i_pc_step};
        if (state_ff == OAD_ST_CALL_HI)
            nxt_pc = call_target_ff; // RQ12
        else if (take && i_req.mode == OAD_M_JUMP)
            nxt_pc = i_req.target;
        else if (take && (i_req.mode == OAD_M_DIR || i_req.mode == OAD_M_IMM || i_req.mode == OAD_M_BIT))
            nxt_pc = pc_ff + {15'h0000, i_pc_step} + 16'h0001; // RQ9 RQ10
    end

    // Next stack pointer: software reload wins over push and pop.
    always_comb
    begin
        nxt_sp = sp_ff;
        if (i_sp_load)
            nxt_sp = i_sp_value; // RQ7
        else if (state_ff == OAD_ST_CALL_HI)
            nxt_sp = 8'(sp_ff + 8'h02);
        else if (take && i_req.mode == OAD_M_PUSH)
            nxt_sp = 8'(sp_ff + 8'h01); // RQ6
        else if (take && i_req.mode == OAD_M_POP)
            nxt_sp = 8'(sp_ff - 8'h01);
    end

    // Program counter register; starts at the reset entry.
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            pc_ff <= `OAD_RESET_PC; // RQ14
        else
            pc_ff <= nxt_pc;
    end

    // Stack pointer register.
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            sp_ff <= `OAD_RESET_SP;
        else
            sp_ff <= nxt_sp;
    end

    // Call target capture; a vector request takes its table entry.
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            call_target_ff <= `OAD_RESET_PC;
        else if (take && i_req.mode == OAD_M_CALL)
            call_target_ff <= i_req.target;
        else if (take && i_req.mode == OAD_M_VECT)
            call_target_ff <= vector; // RQ16
    end

    // State and answer registers.
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_ff <= OAD_ST_IDLE;
            acc_valid_ff <= 1'b0;
            acc_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            acc_valid_ff <= take || (state_ff == OAD_ST_CALL_HI);
            acc_ff <= nxt_acc;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    a_reg_bank_addr: assert property (take && i_req.mode == OAD_M_REG |=> o_acc_valid && o_acc.addr ==
        {11'h000, $past(bank), $past(i_req.opcode[2:0])}) else $error("register address wrong"); // RQ1
    a_dir_split_space: assert property (take && i_req.mode == OAD_M_DIR |=> o_acc.space ==
        ($past(i_req.operand[7]) ? OAD_S_SFR : OAD_S_IRAM)) else $error("direct space wrong"); // RQ3
    a_ind_never_sfr: assert property (take && (i_req.mode == OAD_M_IND || i_req.mode == OAD_M_PUSH)
        |=> o_acc.space == OAD_S_IRAM) else $error("indirect reached special space"); // RQ4
    a_push_sp_up: assert property (take && i_req.mode == OAD_M_PUSH && !i_sp_load |=>
        o_stack_pointer == 8'($past(sp_ff) + 8'h01) && o_acc.addr[7:0] == o_stack_pointer)
        else $error("push pointer wrong"); // RQ6
    a_call_two_push: assert property (take && i_req.mode == OAD_M_CALL && !i_sp_load ##1 !i_sp_load
        |-> !o_ready ##1 o_acc_valid && o_ready && o_pc == $past(i_req.target, 2))
        else $error("call sequence wrong"); // RQ7
    a_imm_pc_step: assert property (take && i_req.mode == OAD_M_IMM && !i_pc_step |=>
        o_pc == 16'($past(pc_ff) + 16'h0001) && o_acc.data == $past(i_req.operand))
        else $error("immediate fetch wrong"); // RQ10
    a_base_sum_addr: assert property (take && i_req.mode == OAD_M_BASE && !i_req.sel |=>
        o_acc.space == OAD_S_PROG && o_acc.addr == 16'($past(i_data_pointer) + {8'h00, $past(i_accumulator)}))
        else $error("table address wrong"); // RQ11
    a_vector_entry: assert property (take && i_req.mode == OAD_M_VECT && i_req.opcode[2:0] == 3'h5
        |-> ##2 o_pc == `OAD_VEC_PWM) else $error("vector wrong"); // RQ16
    a_bit_ram_byte: assert property (take && i_req.mode == OAD_M_BIT && !i_req.operand[7] |=>
        o_acc.addr >= 16'h0020 && o_acc.addr <= 16'h002f && o_acc.bit_valid) else $error("bit byte wrong"); // RQ17
    a_sfr_bit_align: assert property (o_acc_valid && o_acc.bit_valid && o_acc.space == OAD_S_SFR |->
        o_acc.addr[2:0] == 3'h0 && o_acc.addr[7]) else $error("special bit misaligned"); // RQ20

    c_call_seen: cover property (take && i_req.mode == OAD_M_CALL ##2 o_ready);
    c_upper_ind: cover property (take && i_req.mode == OAD_M_IND && i_req.operand[7]);
    c_sfr_bit: cover property (take && i_req.mode == OAD_M_BIT && i_req.operand[7]);
endmodule // oad_core

// ==== tb/oad_mem_model.sv ====
// Memory-side partner of the decoder: tallies every decoded access.
// Assumes each access pulse of the decoder lasts one clock.
`timescale 1ns/1ps
module oad_mem_model import oad_pkg::*; (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // Access from the decoder.
    input wire logic i_acc_valid,
    input wire oad_acc_t i_acc,
    // Access tallies.
    output logic [15:0] o_n_acc,
    output logic [15:0] o_n_sfr
);
    // Counts all accesses, and special register accesses apart.
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_n_acc <= 16'h0000;
            o_n_sfr <= 16'h0000;
        end
        else if (i_acc_valid)
        begin
            o_n_acc <= o_n_acc + 16'h0001;
            o_n_sfr <= o_n_sfr + 16'(i_acc.space == OAD_S_SFR);
        end
    end
endmodule // oad_mem_model

// ==== tb/testbench.sv ====
// Self-checking bench of the operand address decoder.
// Assumes the memory model tallies the decoder's access pulses.
`timescale 1ns/1ps
module testbench import oad_pkg::*;;
    // One table row: request, then the access it should give.
    typedef struct packed {
        oad_mode_t md; logic [7:0] opc; logic [7:0] opr; logic [1:0] bank; logic sel;
        oad_space_t sp; logic [15:0] ad; logic bv; logic [2:0] bi; logic inc; logic pca;
    } oad_row_t;
    logic clk = 1'h0, rst_n = 1'h0, valid = 1'h0, bhi = 1'h0, blo = 1'h0, step = 1'h0, spl = 1'h0;
    logic [7:0] spv = 8'h00, acc_in = 8'h10;
    logic [15:0] data_pointer = 16'hfff8;
    oad_req_t req = '0;
    logic ready, accv;
    oad_acc_t acc;
    logic [15:0] pc, fetch, n_acc, n_sfr, exp_pc = 16'h0000, n_exp = 16'h0000, n_esfr = 16'h0000;
    logic [7:0] sp;
    int n_fail = 0, cmp_count = 0, cyc = 0;
    oad_row_t r;
    // Ordinary cases; addr adds the old pc where pca is set.
    oad_row_t rows [0:16] = '{
        '{OAD_M_REG, 8'h03, 8'h00, 2'h1, 1'h0, OAD_S_IRAM, 16'h000b, 1'h0, 3'h0, 1'h0, 1'h0},
        '{OAD_M_REG, 8'h07, 8'h00, 2'h3, 1'h0, OAD_S_IRAM, 16'h001f, 1'h0, 3'h0, 1'h0, 1'h0},
        '{OAD_M_REG, 8'h00, 8'h00, 2'h0, 1'h0, OAD_S_IRAM, 16'h0000, 1'h0, 3'h0, 1'h0, 1'h0},
        '{OAD_M_REG, 8'h05, 8'h00, 2'h2, 1'h0, OAD_S_IRAM, 16'h0015, 1'h0, 3'h0, 1'h0, 1'h0},
        '{OAD_M_DIR, 8'h00, 8'h7f, 2'h0, 1'h0, OAD_S_IRAM, 16'h007f, 1'h0, 3'h0, 1'h1, 1'h0},
        '{OAD_M_DIR, 8'h00, 8'h80, 2'h0, 1'h0, OAD_S_SFR, 16'h0080, 1'h0, 3'h0, 1'h1, 1'h0},
        '{OAD_M_IND, 8'h00, 8'hc5, 2'h0, 1'h0, OAD_S_IRAM, 16'h00c5, 1'h0, 3'h0, 1'h0, 1'h0},
        '{OAD_M_IMM, 8'h00, 8'h5a, 2'h0, 1'h0, OAD_S_IMM, 16'h0000, 1'h0, 3'h0, 1'h1, 1'h1},
        '{OAD_M_BASE, 8'h00, 8'h00, 2'h0, 1'h0, OAD_S_PROG, 16'h0008, 1'h0, 3'h0, 1'h0, 1'h0},
        '{OAD_M_BASE, 8'h00, 8'h00, 2'h0, 1'h1, OAD_S_PROG, 16'h0010, 1'h0, 3'h0, 1'h0, 1'h1},
        '{OAD_M_BIT, 8'h00, 8'h08, 2'h0, 1'h0, OAD_S_IRAM, 16'h0021, 1'h1, 3'h0, 1'h1, 1'h0},
        '{OAD_M_BIT, 8'h00, 8'h7f, 2'h0, 1'h0, OAD_S_IRAM, 16'h002f, 1'h1, 3'h7, 1'h1, 1'h0},
        '{OAD_M_BIT, 8'h00, 8'hd7, 2'h0, 1'h0, OAD_S_SFR, 16'h00d0, 1'h1, 3'h7, 1'h1, 1'h0},
        '{OAD_M_IMPL, 8'h00, 8'h00, 2'h0, 1'h0, OAD_S_SFR, 16'h00e0, 1'h0, 3'h0, 1'h0, 1'h0},
        '{OAD_M_IMPL, 8'h01, 8'h00, 2'h0, 1'h0, OAD_S_SFR, 16'h00f0, 1'h0, 3'h0, 1'h0, 1'h0},
        '{OAD_M_IMPL, 8'h02, 8'h00, 2'h0, 1'h0, OAD_S_SFR, 16'h0082, 1'h0, 3'h0, 1'h0, 1'h0},
        '{OAD_M_IMPL, 8'h03, 8'h00, 2'h0, 1'h0, OAD_S_SFR, 16'h00d0, 1'h1, 3'h7, 1'h0, 1'h0}
    };
    logic [15:0] vec [0:5] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b};
    // Clock of 50 ns period.
    always #25 clk = ~clk;
    oad_core uut (.i_clk_sys(clk), .i_arst_n(rst_n), .i_req_valid(valid), .i_req(req),
        .i_bank_select_high(bhi), .i_bank_select_low(blo), .i_accumulator(acc_in),
        .i_data_pointer(data_pointer), .i_pc_step(step), .i_sp_load(spl), .i_sp_value(spv),
        .o_ready(ready), .o_acc_valid(accv), .o_acc(acc), .o_pc(pc), .o_fetch_addr(fetch),
        .o_stack_pointer(sp));
    oad_mem_model mem (.i_clk_sys(clk), .i_arst_n(rst_n), .i_acc_valid(accv), .i_acc(acc),
        .o_n_acc(n_acc), .o_n_sfr(n_sfr));
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Checks one access pulse and keeps the expected tallies.
    task automatic chk_acc(input oad_space_t s, input logic [15:0] a);
        chk(16'(accv), 16'h0001);
        chk(16'(acc.space), 16'(s));
        chk(acc.addr, a);
        n_exp = n_exp + 16'h0001;
        n_esfr = n_esfr + 16'(s == OAD_S_SFR);
    endtask
    // Holds one request over the edge that takes it, then lets that edge settle.
    task automatic issue(input oad_mode_t m, input logic [7:0] o, input logic [7:0] d, input logic [15:0] t,
        input logic s, input logic [1:0] b);
        @(posedge clk);
        valid <= 1'h1;
        req <= '{m, o, d, t, s};
        bhi <= b[1];
        blo <= b[0];
        @(posedge clk);
        valid <= 1'h0;
        #1;
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            final_report();
        end
    end
    // Main sequence: reset, table, then stack, call, vector and step cases.
    initial
    begin
        @(posedge clk);
        #1;
        chk(pc, 16'h0000);
        chk(fetch, 16'h0000);
        chk(16'(sp), 16'h0007);
        chk(16'(ready), 16'h0001);
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        foreach (rows[k])
        begin
            r = rows[k];
            issue(r.md, r.opc, r.opr, 16'h0000, r.sel, r.bank);
            chk_acc(r.sp, r.ad + (r.pca ? exp_pc : 16'h0000));
            chk(16'(acc.bit_valid), 16'(r.bv));
            if (r.bv)
                chk(16'(acc.bit_idx), 16'(r.bi));
            if (r.md == OAD_M_IMM)
                chk(16'(acc.data), 16'(r.opr));
            exp_pc = exp_pc + 16'(r.inc);
            chk(pc, exp_pc);
        end
        issue(OAD_M_PUSH, 8'h00, 8'he0, 16'h0000, 1'h0, 2'h0);
        chk_acc(OAD_S_IRAM, 16'h0008);
        chk({acc.src_valid, 4'(acc.src_space), acc.src_addr}, 16'h12e0);
        chk(16'(sp), 16'h0008);
        issue(OAD_M_POP, 8'h00, 8'h00, 16'h0000, 1'h0, 2'h0);
        chk_acc(OAD_S_IRAM, 16'h0008);
        chk(16'(sp), 16'h0007);
        issue(OAD_M_CALL, 8'h00, 8'h00, 16'hbeef, 1'h0, 2'h0);
        chk_acc(OAD_S_IRAM, 16'h0008);
        chk(16'(acc.data), 16'(exp_pc[7:0]));
        chk(16'(ready), 16'h0000);
        @(posedge clk);
        #1;
        chk_acc(OAD_S_IRAM, 16'h0009);
        chk(16'(acc.data), 16'(exp_pc[15:8]));
        chk(pc, 16'hbeef);
        for (int i = 0; i < 6; i++)
        begin
            issue(OAD_M_VECT, 8'(i), 8'h00, 16'h0000, 1'h0, 2'h0);
            chk_acc(OAD_S_IRAM, 16'(8'h0a + 8'(2 * i)));
            @(posedge clk);
            #1;
            chk_acc(OAD_S_IRAM, 16'(8'h0b + 8'(2 * i)));
            chk(pc, vec[i]);
        end
        @(posedge clk);
        spl <= 1'h1;
        spv <= 8'hfe;
        step <= 1'h1;
        @(posedge clk);
        spl <= 1'h0;
        step <= 1'h0;
        #1;
        chk(16'(sp), 16'h00fe);
        chk(pc, 16'h002c);
        for (int i = 0; i < 2; i++)
        begin
            issue(OAD_M_PUSH, 8'h00, 8'h30, 16'h0000, 1'h0, 2'h0);
            chk_acc(OAD_S_IRAM, {8'h00, 8'(8'hff + 8'(i))});
        end
        // A jump gives an empty access and loads the counter.
        issue(OAD_M_JUMP, 8'h00, 8'h00, 16'h1234, 1'h0, 2'h0);
        chk_acc(OAD_S_NONE, 16'h0000);
        chk(pc, 16'h1234);
        chk(fetch, 16'h1234);
        @(posedge clk);
        #1;
        chk(n_acc, n_exp);
        chk(n_sfr, n_esfr);
        // Reset in mid-run clears the state at once, without waiting for an edge.
        @(posedge clk);
        rst_n <= 1'h0;
        #1;
        chk(pc, 16'h0000);
        chk(16'(sp), 16'h0007);
        chk(16'(accv), 16'h0000);
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        acc_in <= 8'h05;
        data_pointer <= 16'h1000;
        issue(OAD_M_DIR, 8'h00, 8'h90, 16'h0000, 1'h0, 2'h0);
        chk_acc(OAD_S_SFR, 16'h0090);
        chk(pc, 16'h0001);
        issue(OAD_M_BASE, 8'h00, 8'h00, 16'h0000, 1'h0, 2'h0);
        chk_acc(OAD_S_PROG, 16'h1005);
        final_report();
    end
endmodule // testbench
